// *** rtl/sso_defines.vh ***
/*
 * Constants for the sink status output logic: contract flag configuration
 * codes, advertised current codes and reset values of the open-drain pins.
 * Assumes: included by rtl/sso_status_out.v only; holds definitions only.
 */
// How it works
// - CC pins high impedance during reset
// - Discharge pin follows internal discharge path
// - Discharge on detach, lower PDO, reset, recovery
// - Discharge time from nonvolatile setting
// - Discharge pin open drain, low when active
// - Attach low once source connection valid
// - Attach low on debug accessory too
// - Flag meaning from 2-bit start-up field
// - Code 00: path enable only, flags released
// - Code 10: flags mark PDO2/PDO3 contracts
// - Code 11: flags mark 3.0A/1.5A advertisement
// - Low-voltage flag active-low open drain
// - Default flags assert on supply-ready message
// - Flags hold on detach, clear on reset and, in code 10, on attach
`ifndef SSO_DEFINES_VH
`define SSO_DEFINES_VH

// ============================================================
// Contract flag configuration codes
`define SSO_CFG_PATH_ONLY   2'h0
`define SSO_CFG_RESERVED    2'h1
`define SSO_CFG_PDO_FLAGS   2'h2
`define SSO_CFG_CURRENT     2'h3

// ============================================================
// Advertised Type-C current codes from the CC-line logic
`define SSO_CUR_DEFAULT     2'h0
`define SSO_CUR_1A5         2'h1
`define SSO_CUR_3A0         2'h2

// ============================================================
// Negotiated profile indices from the PD engine
`define SSO_PDO2            2'h2
`define SSO_PDO3            2'h3

// ============================================================
// Widths and reset values
`define SSO_DTIME_W         16
`define SSO_DTIME_ZERO      16'h0000
`define SSO_DTIME_ONE       16'h0001
`define SSO_REL             1'h0
`define SSO_ON              1'h1

`endif

// *** rtl/sso_status_out.v ***
/*
 * Sink status output logic: attach, sink path enable, two contract flags,
 * discharge control and CC pin release during reset.
 * Assumes: event inputs are one-cycle pulses synchronous to clk_sys from the
 * CC-line state machine and the PD engine; the nonvolatile configuration is
 * valid while the start-up load strobe pulses. Open-drain pins are modelled
 * as output-enable only; the pin level is worked out outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"

module sso_status_out (
    input  wire                    clk_sys,        // 200 MHz system clock
    input  wire                    sys_rst,        // Synchronous reset, active high
    input  wire                    nvm_load,       // Start-up configuration load pulse
    input  wire [1:0]              nvm_flag_cfg,   // Contract flag configuration field
    input  wire [`SSO_DTIME_W-1:0] nvm_discharge_ctrl_time, // Discharge duration in cycles
    input  wire                    src_attached,   // Valid source-to-sink connection
    input  wire                    dbg_attached,   // Debug accessory attached
    input  wire                    detach_evt,     // Cable disconnection pulse
    input  wire                    lower_pdo_evt,  // Transition to lower voltage pulse
    input  wire                    hard_rst_evt,   // Hard reset pulse
    input  wire                    err_rec_evt,    // Error recovery entry pulse
    input  wire                    ps_ready_evt,   // Supply-ready message received pulse
    input  wire                    rdo_sent_evt,   // New request message sent pulse
    input  wire [1:0]              pdo_index,      // Negotiated profile index
    input  wire [1:0]              adv_current,    // Advertised Type-C current
    output reg                     cc_term_en,     // CC1/CC2 termination enable, low is HiZ
    output reg                     attach_oe,      // Attach pin pulled low
    output reg                     sink_path_enable_oe, // Sink path enable pulled low
    output reg                     contract_flag_hv_oe, // High-voltage flag pulled low
    output reg                     contract_flag_lv_oe, // Low-voltage flag pulled low
    output reg                     discharge_ctrl_oe,   // Discharge pin pulled low
    output reg                     bus_sense_discharge_en, // Internal discharge path on
    output reg [1:0]               contract_flag_config    // Latched configuration field
);

    // ============================================================
    // Internal state
    reg [`SSO_DTIME_W-1:0] discharge_ctrl_cnt;      // Discharge cycles left
    reg                    src_prev;       // Attach level one cycle back
    reg                    flag_hv;        // Registered flag state, same as contract_flag_hv_oe
    reg                    flag_lv;        // Registered flag state, same as contract_flag_lv_oe
    reg                    next_flag_hv;   // Next flag value
    reg                    next_flag_lv;   // Next flag value
    wire                   discharge_ctrl_start;    // Any discharge trigger
    wire                   new_attach;     // Rising edge of source attach

    assign discharge_ctrl_start = detach_evt | lower_pdo_evt | hard_rst_evt | err_rec_evt;
    assign new_attach  = src_attached & ~src_prev;

    // ============================================================
    // Configuration latch: loaded once at start-up, survives reset
    // so a reset pulse does not lose the nonvolatile setting.
    always @(posedge clk_sys) begin
        if (nvm_load) begin
            contract_flag_config <= nvm_flag_cfg;
        end
    end

    // ============================================================
    // Flag next-state decode per configuration
    always @* begin
        next_flag_hv = flag_hv;
        next_flag_lv = flag_lv;
        case (contract_flag_config)
            `SSO_CFG_PDO_FLAGS: begin
                // A new request drops the old flag; supply-ready sets the new one
                if (new_attach) begin
                    next_flag_hv = `SSO_REL;
                    next_flag_lv = `SSO_REL;
                end else if (ps_ready_evt) begin
                    next_flag_hv = (pdo_index == `SSO_PDO2);
                    next_flag_lv = (pdo_index == `SSO_PDO3);
                end else if (rdo_sent_evt) begin
                    next_flag_hv = `SSO_REL;
                    next_flag_lv = `SSO_REL;
                end
                // Detach leaves flags as they are
            end
            `SSO_CFG_CURRENT: begin
                if (src_attached) begin
                    next_flag_hv = (adv_current == `SSO_CUR_3A0);
                    next_flag_lv = (adv_current == `SSO_CUR_1A5);
                end else if (new_attach) begin
                    next_flag_hv = `SSO_REL;
                    next_flag_lv = `SSO_REL;
                end
                // Detached: held, as flags stay asserted over detach
            end
            `SSO_CFG_PATH_ONLY: begin
                next_flag_hv = `SSO_REL;
                next_flag_lv = `SSO_REL;
            end
            default: begin
                // Reserved code: no flag function
                next_flag_hv = `SSO_REL;
                next_flag_lv = `SSO_REL;
            end
        endcase
    end

    // ============================================================
    // Status pins and discharge timer
    // Reset comes from the system, held high to stop the device.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            cc_term_en             <= `SSO_REL;
            attach_oe              <= `SSO_REL;
            sink_path_enable_oe    <= `SSO_REL;
            contract_flag_hv_oe    <= `SSO_REL;
            contract_flag_lv_oe    <= `SSO_REL;
            discharge_ctrl_oe      <= `SSO_REL;
            bus_sense_discharge_en <= `SSO_REL;
            flag_hv                <= `SSO_REL;
            flag_lv                <= `SSO_REL;
            discharge_ctrl_cnt              <= `SSO_DTIME_ZERO;
            src_prev               <= `SSO_REL;
        end else begin
            cc_term_en          <= `SSO_ON;
            src_prev            <= src_attached;
            attach_oe           <= src_attached | dbg_attached;
            // Path enable follows attach in every configuration; drops on detach
            sink_path_enable_oe <= src_attached;
            flag_hv             <= next_flag_hv;
            flag_lv             <= next_flag_lv;
            contract_flag_hv_oe <= next_flag_hv;
            contract_flag_lv_oe <= next_flag_lv;
            // Timer reloads on each trigger when the setting is nonzero; length from nvm_discharge_ctrl_time as it is at the trigger
            if (discharge_ctrl_start && (nvm_discharge_ctrl_time != `SSO_DTIME_ZERO)) begin
                discharge_ctrl_cnt              <= nvm_discharge_ctrl_time;
                bus_sense_discharge_en <= `SSO_ON;
                discharge_ctrl_oe      <= `SSO_ON;
            end else if (discharge_ctrl_cnt > `SSO_DTIME_ONE) begin
                discharge_ctrl_cnt <= discharge_ctrl_cnt - `SSO_DTIME_ONE;
            end else begin
                discharge_ctrl_cnt              <= `SSO_DTIME_ZERO;
                bus_sense_discharge_en <= `SSO_REL;
                discharge_ctrl_oe      <= `SSO_REL;
            end
        end
    end

endmodule // sso_status_out
`default_nettype wire

// *** bench/sso_host_model.sv ***
/* Host side of the open-drain status pins: pull-ups and pin levels.
   Assumes: oe high means the device pulls the pin low. */
`timescale 1ns/1ps
`default_nettype none
module sso_host_model (
    input  wire logic [4:0] pull_low,  // Attach, path, hv flag, lv flag, discharge
    output var  logic [4:0] pin_level  // Level seen by the power system
);
    // ============================================================
    // Pull-ups win whenever the device lets go of a pin
    always_comb pin_level = ~pull_low;
endmodule // sso_host_model
`default_nettype wire

// *** bench/sso_status_out_monitor.sv ***
/* Port-level checker for sso_status_out.
   Assumes: bound to every instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module sso_status_out_monitor (
    input wire logic        clk_sys, sys_rst, src_attached, dbg_attached, // Clock and levels
    input wire logic        detach_evt, lower_pdo_evt, hard_rst_evt, err_rec_evt, // Events
    input wire logic        ps_ready_evt, cc_term_en, attach_oe, sink_path_enable_oe, // Pins
    input wire logic        contract_flag_hv_oe, contract_flag_lv_oe, discharge_ctrl_oe, // Pins
    input wire logic [1:0]  pdo_index, adv_current, contract_flag_config, // Codes
    input wire logic [15:0] nvm_discharge_ctrl_time // Discharge length
);
    // ============================================================
    // Helpers; reset disables all but the reset checks
    wire logic any_evt = detach_evt | lower_pdo_evt | hard_rst_evt | err_rec_evt; // Starts
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // Properties
    cc_hiz_a: assert property (disable iff (1'b0) sys_rst |=> !cc_term_en)
        else $error("CC driven in reset");
    pins_rel_a: assert property (disable iff (1'b0) sys_rst |=> !(attach_oe
        | sink_path_enable_oe | contract_flag_hv_oe | contract_flag_lv_oe | discharge_ctrl_oe))
        else $error("Pin pulled in reset");
    attach_a: assert property (1'b1 |=> attach_oe ==
        ($past(src_attached) | $past(dbg_attached))) else $error("Attach wrong");
    discharge_ctrl_start_a: assert property (any_evt && nvm_discharge_ctrl_time == 16'h0003
        |=> discharge_ctrl_oe[*3]) else $error("Discharge short");
    discharge_ctrl_end_a: assert property (any_evt && nvm_discharge_ctrl_time == 16'h0003 ##1 !any_evt[*3]
        |=> !discharge_ctrl_oe) else $error("Discharge long");
    flags_off_a: assert property (!contract_flag_config[1]
        |-> !contract_flag_hv_oe && !contract_flag_lv_oe) else $error("Flag in code 0x");
    pdo_flag_a: assert property (contract_flag_config == 2'h2 && ps_ready_evt
        && !$rose(src_attached) |=> contract_flag_hv_oe == ($past(pdo_index) == 2'h2)
        && contract_flag_lv_oe == ($past(pdo_index) == 2'h3)) else $error("PDO flag wrong");
    cur_a: assert property (contract_flag_config == 2'h3 && src_attached
        |=> contract_flag_hv_oe == ($past(adv_current) == 2'h2)
        && contract_flag_lv_oe == ($past(adv_current) == 2'h1)) else $error("Current flag");
endmodule // sso_status_out_monitor
bind sso_status_out sso_status_out_monitor u_mon (.*);
`default_nettype wire

// *** bench/tb_sink_status_output_logic.sv ***
/* Random events against a cycle model, once per flag code.
   Assumes: design, host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_sink_status_output_logic;
    // ============================================================
    // Stimulus, outputs and model state
    logic        clk_sys = 0, sys_rst = 1, nvm_load = 0, src = 0, dbg = 0, ps = 0, rdo = 0;
    logic [3:0]  evt = 4'h0;                      // Discharge start pulses
    logic [1:0]  cfg = 2'h0, pdo = 2'h2, adv = 2'h0; // Code, profile, current
    logic [15:0] dtime = 16'h0000;                // Discharge length
    wire logic [8:0] got;                         // Design outputs
    wire logic [4:0] pins;                        // Pin levels
    logic [8:0]  m_o;                             // Model outputs
    logic        m_prev = 0, m_hv = 0, m_lv = 0;  // Last attach and flags
    logic [1:0]  m_cfg;                           // Latched code
    integer      m_cnt = 0, fail_count = 0, num_checks = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    sso_status_out dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .nvm_load(nvm_load),
        .nvm_flag_cfg(cfg), .nvm_discharge_ctrl_time(dtime), .src_attached(src), .dbg_attached(dbg),
        .detach_evt(evt[0]), .lower_pdo_evt(evt[1]), .hard_rst_evt(evt[2]),
        .err_rec_evt(evt[3]), .ps_ready_evt(ps), .rdo_sent_evt(rdo), .pdo_index(pdo),
        .adv_current(adv), .contract_flag_config(got[8:7]), .cc_term_en(got[6]),
        .attach_oe(got[5]), .sink_path_enable_oe(got[4]), .contract_flag_hv_oe(got[3]),
        .contract_flag_lv_oe(got[2]), .discharge_ctrl_oe(got[1]),
        .bus_sense_discharge_en(got[0]));
    sso_host_model host (.pull_low(got[5:1]), .pin_level(pins));
    // ============================================================
    // Reference model, one step per edge
    always @(posedge clk_sys) begin
        if (nvm_load) m_cfg = cfg;
        if (sys_rst) begin
            m_cnt = 0;
            {m_hv, m_lv} = 2'h0;
        end else begin
            if (evt != 4'h0 && dtime != 16'h0000) m_cnt = dtime;
            else if (m_cnt > 0) m_cnt = m_cnt - 1;
            if (m_cfg == 2'h3 && src) {m_hv, m_lv} = {adv == 2'h2, adv == 2'h1};
            else if (m_cfg == 2'h2 && src && !m_prev) {m_hv, m_lv} = 2'h0;
            else if (m_cfg == 2'h2 && ps) {m_hv, m_lv} = {pdo == 2'h2, pdo == 2'h3};
            else if (m_cfg == 2'h2 && rdo) {m_hv, m_lv} = 2'h0;
            else if (m_cfg < 2'h2) {m_hv, m_lv} = 2'h0;
        end
        m_o = {m_cfg, !sys_rst, !sys_rst && (src || dbg), !sys_rst && src, m_hv, m_lv,
            {2{m_cnt > 0}}};
        m_prev = src;
    end
    // ============================================================
    // Compare on the falling edge, where outputs are settled
    always @(negedge clk_sys) begin
        check(got, m_o);
        check({4'h0, pins}, {4'h0, ~m_o[5:1]});
        cycles = cycles + 1;
        if (cycles > 3000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %b want %b", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // Each code: reset with load, then random traffic
    initial begin
        void'($urandom(38));
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys);
            #1;
            sys_rst = 1;
            nvm_load = 1;
            cfg = c[1:0];
            dtime = (c == 1) ? 16'h0000 : 16'h0003;
            {src, dbg, evt, ps, rdo} = 8'h00;
            repeat (5) @(posedge clk_sys);
            #1;
            sys_rst = 0;
            nvm_load = 0;
            repeat (400) begin
                @(posedge clk_sys);
                #1;
                if ($urandom % 40 == 0) src = ~src;
                if ($urandom % 60 == 0) dbg = ~dbg;
                evt = ($urandom % 12 == 0) ? 4'h1 << ($urandom % 4) : 4'h0;
                adv = 2'($urandom % 3);
                pdo = 2'h2 + 2'($urandom % 2);
                ps = src && m_prev && !m_hv && !m_lv && ($urandom % 6 == 0);
                rdo = ($urandom % 20 == 0);
            end
        end
        conclude();
    end
endmodule // tb_sink_status_output_logic
`default_nettype wire
